// ---- rfsdc_top.sv ----
// synthesizer dividers, phase detector, amplifier keying and converter
// clock; CLK_SYS stands for the crystal clock, VCO_IN/TX_DATA/MODE are pins
`timescale 1ns/1ns
`include "rfsdc_map.svh"
module rfsdc_top
    import rfsdc_pkg::*;
#(
    parameter int PRESC_LO = 32
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_B,
    input  wire logic [4:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        VCO_IN,
    input  wire logic        TX_DATA,
    input  wire logic        MODE,
    output logic             FDIV_OUT,
    output logic             FREF_OUT,
    output logic             PUMP_UP,
    output logic             PUMP_DN,
    output logic      [2:0]  CP_SEL,
    output logic      [1:0]  PA_STATE,
    output logic             PA_ON,
    output logic             XTAL_PULL,
    output logic      [2:0]  XTAL_TRIM,
    output logic             VCO_EN,
    output logic             DCDC_CLK
);
    //===================================================================
    // elaboration check
    if (PRESC_LO < 2 || PRESC_LO > 62) begin : g_bad
        $error("PRESC_LO out of range");
    end

    localparam logic [5:0] PRE_LO = 6'(PRESC_LO - 1);
    localparam logic [5:0] PRE_HI = 6'(PRESC_LO);

    rfsdc_state_s s_reg;
    rfsdc_state_s s_next;
    logic         req;
    logic         wr_go;
    logic [23:0]  sel;
    logic         vco_rise;
    logic         key;
    logic         mode_hi;
    logic [4:0]  swal;
    logic [8:0]  prog;
    logic [7:0]  ref_lim;
    logic [6:0]  l_div;
    logic        last_pre;

    //===================================================================
    // byte-lane merge, limited to implemented bits
    function automatic logic [23:0] merge(input logic [23:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be,
                                          input logic [23:0] mask);
        logic [23:0] v;
        v = old;
        for (int i = 0; i < 3; i++) begin
            if (be[i]) begin
                v[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return v & mask;
    endfunction : merge

    //===================================================================
    // bus slave: one wait state, read data registered
    assign req             = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = req & ~s_reg.ack;
    assign wr_go           = AVS_WRITE & s_reg.ack;
    assign AVS_READDATA    = s_reg.rdata;

    //===================================================================
    // selected config and decoded fields
    assign key     = s_reg.filt[1];
    assign mode_hi = s_reg.filt[2];
    assign sel     = mode_hi ? s_reg.cfg1 : s_reg.cfg0; // [R17]
    assign swal    = sel[`RFSDC_SW_MSB:`RFSDC_SW_LSB];
    assign prog    = sel[`RFSDC_PG_MSB:`RFSDC_PG_LSB];
    // divisor 0 wraps to 255 here, which gives the 256 period
    assign ref_lim = s_reg.clkdiv[`RFSDC_REF_MSB:`RFSDC_REF_LSB] - 8'h01;
    assign l_div   = s_reg.clkdiv[`RFSDC_L_MSB:`RFSDC_L_LSB];
    assign vco_rise = s_reg.filt[0] == 1'b0 && s_reg.s2[0] == s_reg.s3[0]
                      && s_reg.s3[0] == 1'b1;
    // swallow phase stretches the prescaler by one
    assign last_pre = s_reg.pre_cnt ==
                      ((s_reg.sw_cnt < swal) ? PRE_HI : PRE_LO); // [R2]

    always_comb begin
        s_next = s_reg;
        //---------------------------------------------------------------
        // registers
        s_next.ack = req & ~s_reg.ack;
        if (AVS_READ & ~s_reg.ack) begin
            case (AVS_ADDRESS[4:2])
                `RFSDC_OFS_CFG0:   s_next.rdata = {8'h00, s_reg.cfg0};
                `RFSDC_OFS_CFG1:   s_next.rdata = {8'h00, s_reg.cfg1};
                `RFSDC_OFS_CLKDIV: s_next.rdata = {8'h00, s_reg.clkdiv};
                `RFSDC_OFS_TRIM:   s_next.rdata = {8'h00, s_reg.trim};
                `RFSDC_OFS_STATUS: s_next.rdata = {22'h000000,
                    s_reg.vco_en, s_reg.pa_on, s_reg.pull, mode_hi,
                    s_reg.up, s_reg.dn, s_reg.pa, s_reg.fdiv, s_reg.fref};
                default:           s_next.rdata = 32'h00000000;
            endcase
        end
        if (wr_go) begin
            case (AVS_ADDRESS[4:2])
                `RFSDC_OFS_CFG0: s_next.cfg0 = merge(s_reg.cfg0,
                    AVS_WRITEDATA, AVS_BYTEENABLE, `RFSDC_CFG0_MASK);
                `RFSDC_OFS_CFG1: s_next.cfg1 = merge(s_reg.cfg1,
                    AVS_WRITEDATA, AVS_BYTEENABLE, `RFSDC_CFG1_MASK);
                `RFSDC_OFS_CLKDIV: s_next.clkdiv = merge(s_reg.clkdiv,
                    AVS_WRITEDATA, AVS_BYTEENABLE, `RFSDC_CLK_MASK);
                `RFSDC_OFS_TRIM: s_next.trim = merge(s_reg.trim,
                    AVS_WRITEDATA, AVS_BYTEENABLE, `RFSDC_TRIM_MASK);
                default: ;
            endcase
        end
        //---------------------------------------------------------------
        // pin synchronisers: a change counts when stages two and three agree
        s_next.s1 = {MODE, TX_DATA, VCO_IN};
        s_next.s2 = s_reg.s1;
        s_next.s3 = s_reg.s2;
        for (int i = 0; i < 3; i++) begin
            if (s_reg.s2[i] == s_reg.s3[i]) begin
                s_next.filt[i] = s_reg.s3[i];
            end
        end
        //---------------------------------------------------------------
        // dual-modulus main divider
        s_next.fdiv = 1'b0;
        if (vco_rise) begin
            if (last_pre) begin
                s_next.pre_cnt = 6'h00;
                if (s_reg.sw_cnt < swal) begin
                    s_next.sw_cnt = s_reg.sw_cnt + 5'h01; // [R1]
                end
                if (s_reg.prog_cnt == prog - 9'h001) begin
                    s_next.prog_cnt = 9'h000; // [R3]
                    s_next.sw_cnt   = 5'h00; // [R2]
                    s_next.fdiv     = 1'b1;
                end else begin
                    s_next.prog_cnt = s_reg.prog_cnt + 9'h001; // [R1]
                end
            end else begin
                s_next.pre_cnt = s_reg.pre_cnt + 6'h01;
            end
        end
        //---------------------------------------------------------------
        // reference divider
        s_next.fref = 1'b0;
        if (s_reg.ref_cnt >= ref_lim) begin
            s_next.ref_cnt = 8'h00; // [R4]
            s_next.fref    = 1'b1;
        end else begin
            s_next.ref_cnt = s_reg.ref_cnt + 8'h01;
        end
        //---------------------------------------------------------------
        // phase-frequency detector; both set clears both, so no overlap
        s_next.up = s_reg.up | s_reg.fref; // [R5]
        s_next.dn = s_reg.dn | s_reg.fdiv; // [R5]
        if ((s_next.up & s_next.dn) | s_reg.trim[`RFSDC_PFDR_BIT]) begin
            s_next.up = 1'b0;
            s_next.dn = 1'b0;
        end
        case (sel[`RFSDC_CP_MSB:`RFSDC_CP_LSB])
            2'h0:    s_next.cp_sel = 3'h2; // [R6] [R19]
            2'h1:    s_next.cp_sel = 3'h4; // [R6] [R19]
            2'h2:    s_next.cp_sel = 3'h1; // [R6] [R19]
            default: s_next.cp_sel = 3'h0;
        endcase
        //---------------------------------------------------------------
        // amplifier state and keying
        if (!sel[`RFSDC_TX_BIT]) begin
            s_next.pa = PA_OFF; // [R7] [R8]
        end else begin
            case (sel[`RFSDC_ATT_MSB:`RFSDC_ATT_LSB])
                2'h0:    s_next.pa = PA_ATT10; // [R18]
                2'h1:    s_next.pa = PA_ATT20; // [R18]
                2'h2:    s_next.pa = PA_FULL; // [R18]
                default: s_next.pa = PA_ATT20; // undefined code: least power
            endcase
        end
        s_next.pa_on = sel[`RFSDC_TX_BIT] &
                       (s_reg.cfg1[`RFSDC_FSK_BIT] | key); // [R9] [R8]
        // pull only in fsk, so on-off keying never moves the carrier
        s_next.pull  = s_reg.cfg1[`RFSDC_FSK_BIT] & key; // [R10] [R11]
        s_next.xtrim = s_reg.trim[`RFSDC_TRIM_MSB:`RFSDC_TRIM_LSB]; // [R16]
        //---------------------------------------------------------------
        // converter clock and oscillator enable
        s_next.vco_en = !(s_reg.cfg0[`RFSDC_DCDC_BIT] &&
                          l_div == 7'h00); // [R20] [R8]
        if (!s_reg.cfg0[`RFSDC_DCDC_BIT] || l_div == 7'h00) begin
            s_next.l_cnt    = 7'h00;
            s_next.dcdc_clk = 1'b0;
        end else if (s_reg.l_cnt >= l_div - 7'h01) begin
            s_next.l_cnt    = 7'h00; // [R14]
            s_next.dcdc_clk = ~s_reg.dcdc_clk; // [R14]
        end else begin
            s_next.l_cnt = s_reg.l_cnt + 7'h01;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            s_reg        <= '0;
            s_reg.cfg0   <= `RFSDC_CFG_RST;
            s_reg.cfg1   <= `RFSDC_CFG_RST;
            s_reg.clkdiv <= `RFSDC_CLK_RST;
            s_reg.trim   <= `RFSDC_TRIM_RST;
            s_reg.pa     <= PA_OFF;
        end else begin
            s_reg <= s_next;
        end
    end

    assign FDIV_OUT  = s_reg.fdiv;
    assign FREF_OUT  = s_reg.fref;
    assign PUMP_UP   = s_reg.up;
    assign PUMP_DN   = s_reg.dn;
    assign CP_SEL    = s_reg.cp_sel;
    assign PA_STATE  = s_reg.pa;
    assign PA_ON     = s_reg.pa_on;
    assign XTAL_PULL = s_reg.pull;
    assign XTAL_TRIM = s_reg.xtrim;
    assign VCO_EN    = s_reg.vco_en;
    assign DCDC_CLK  = s_reg.dcdc_clk;

    //===================================================================
    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);

    AST_SWALLOW_BOUND: assert property ( // [R2]
        s_reg.sw_cnt <= swal || $changed(swal))
        else $error("swallow counter past its limit");
    AST_FDIV_WRAP: assert property ( // [R3]
        FDIV_OUT && $stable(prog) |-> $past(s_reg.prog_cnt) == prog - 9'h001)
        else $error("feedback pulse not at program end");
    AST_REF_BOUND: assert property ( // [R4]
        FREF_OUT && $stable(ref_lim) |=> s_reg.ref_cnt == 8'h01 ||
        (ref_lim == 8'h00 && FREF_OUT))
        else $error("reference count did not restart");
    AST_PUMP_EXCL: assert property ( // [R5]
        !(PUMP_UP && PUMP_DN))
        else $error("both pumps on");
    AST_PUMP_HOLD: assert property ( // [R5]
        s_reg.trim[`RFSDC_PFDR_BIT] |=> !PUMP_UP && !PUMP_DN)
        else $error("pumps active during detector reset");
    AST_CP_CODE: assert property ( // [R19]
        sel[`RFSDC_CP_MSB:`RFSDC_CP_LSB] == 2'h2 |=> CP_SEL == 3'h1)
        else $error("pump code 10 not lowest current");
    AST_RX_OFF: assert property ( // [R8]
        !sel[`RFSDC_TX_BIT] |=> PA_STATE == PA_OFF && !PA_ON)
        else $error("amplifier active in receive");
    AST_OOK_KEY: assert property ( // [R9]
        sel[`RFSDC_TX_BIT] && !s_reg.cfg1[`RFSDC_FSK_BIT] |=>
        PA_ON == $past(key))
        else $error("amplifier does not follow key");
    AST_OOK_NOPULL: assert property ( // [R11]
        !s_reg.cfg1[`RFSDC_FSK_BIT] |=> !XTAL_PULL)
        else $error("pull switched in on-off keying");
    AST_FULL_PWR: assert property ( // [R18]
        sel[`RFSDC_TX_BIT] && sel[`RFSDC_ATT_MSB:`RFSDC_ATT_LSB] ==
        `RFSDC_ATT_FULL |=> PA_STATE == PA_FULL)
        else $error("code 10 not full power");
    AST_VCO_STOP: assert property ( // [R20]
        s_reg.cfg0[`RFSDC_DCDC_BIT] && l_div == 7'h00 |=> !VCO_EN ##0
        !DCDC_CLK)
        else $error("oscillator runs with zero converter divisor");
    AST_DCDC_EVEN: assert property ( // [R14]
        $rose(DCDC_CLK) && l_div == 7'h01 && $stable(l_div) |=> !DCDC_CLK)
        else $error("converter divide-by-2 wrong");
    AST_FSK_PULL: assert property ( // [R10]
        s_reg.cfg1[`RFSDC_FSK_BIT] |=> XTAL_PULL == $past(key))
        else $error("pull does not follow key in fsk");
    AST_TRIM_COPY: assert property ( // [R16]
        XTAL_TRIM == $past(s_reg.trim[`RFSDC_TRIM_MSB:`RFSDC_TRIM_LSB]))
        else $error("trim output not the trim field");
    AST_RX_VCO: assert property ( // [R8]
        !sel[`RFSDC_TX_BIT] && !s_reg.cfg0[`RFSDC_DCDC_BIT] |=> VCO_EN)
        else $error("oscillator stopped in receive");
    AST_ATT10: assert property ( // [R7]
        sel[`RFSDC_TX_BIT] && sel[`RFSDC_ATT_MSB:`RFSDC_ATT_LSB] == 2'h0
        |=> PA_STATE == PA_ATT10)
        else $error("code 00 not 10 db state");
    AST_CP_FULL: assert property ( // [R6]
        sel[`RFSDC_CP_MSB:`RFSDC_CP_LSB] == 2'h1 |=> CP_SEL == 3'h4)
        else $error("pump code 01 not highest current");
    AST_DCDC_OFF: assert property ( // [R14]
        !s_reg.cfg0[`RFSDC_DCDC_BIT] |=> !DCDC_CLK)
        else $error("converter clock runs while converter off");

    COV_FDIV: cover property (FDIV_OUT && swal != 5'h00);
    COV_LOCKSTEP: cover property (FREF_OUT ##1 PUMP_UP ##[1:40] !PUMP_UP);
    COV_FSK_PULL: cover property (PA_ON && $rose(XTAL_PULL));
    COV_MODE_SWAP: cover property ($rose(mode_hi) ##2 PA_STATE != PA_OFF);
    COV_DCDC_RUN: cover property ($rose(DCDC_CLK) ##1 !DCDC_CLK);

endmodule : rfsdc_top

// ---- rfsdc_map.svh ----
// register offsets, field positions and reset values of the synthesizer
// divider and keying block; assumes byte addresses on a 32-bit avalon bus
//=======================================================================
// How it works
// [R1] main divider: 5-bit swallow, 9-bit program counter, 33/32 prescaler
// [R2] prescale by 33 until swallow ends, then 32 until program ends
// [R3] total division is swallow plus 32 times program; host keeps ranges
// [R4] 8-bit reference divisor, 1 to 256, sets comparison rate
// [R5] phase-frequency detector drives up and down charge pumps
// [R6] two-bit field picks pump current of 250, 500 or 1000 ua
// [R7] amplifier states: full, 10 db, 20 db, off for receive
// [R8] receive powers amplifier down but keeps oscillator running
// [R9] on-off keying: key input switches amplifier bit by bit
// [R10] frequency keying: key input switches crystal pull capacitor
// [R11] on-off keying leaves oscillator frequency unchanged
// [R12] host holds key input low during receive
// [R13] host accounts for inverted data with high-side oscillator
// [R14] converter clock is crystal divided by even 2 to 254
// [R15] host programs converter divisor 16 or 32 for 20 mhz crystal
// [R16] trim field switches crystal capacitors
// [R17] mode pin low selects first config word, high the second
// [R18] attenuation 00 10 db, 01 20 db, 10 0 db; reset 0 db
// [R19] pump field 00 0.5 ma, 01 1 ma, 10 0.25 ma, 11 undefined
// [R20] converter on with zero divisor stops the oscillator
`ifndef RFSDC_MAP_SVH
`define RFSDC_MAP_SVH
//=======================================================================
// offsets
`define RFSDC_OFS_CFG0    3'h0
`define RFSDC_OFS_CFG1    3'h1
`define RFSDC_OFS_CLKDIV  3'h2
`define RFSDC_OFS_TRIM    3'h3
`define RFSDC_OFS_STATUS  3'h4
//=======================================================================
// config word fields
`define RFSDC_SW_MSB      21
`define RFSDC_SW_LSB      17
`define RFSDC_PG_MSB      16
`define RFSDC_PG_LSB      8
`define RFSDC_ATT_MSB     7
`define RFSDC_ATT_LSB     6
`define RFSDC_TX_BIT      5
`define RFSDC_FSK_BIT     4
`define RFSDC_CP_MSB      3
`define RFSDC_CP_LSB      2
`define RFSDC_DCDC_BIT    0
// clock divider word fields
`define RFSDC_REF_MSB     21
`define RFSDC_REF_LSB     14
`define RFSDC_L_MSB       6
`define RFSDC_L_LSB       0
// trim word fields
`define RFSDC_TRIM_MSB    18
`define RFSDC_TRIM_LSB    16
`define RFSDC_PFDR_BIT    15
//=======================================================================
// reset values and writable masks
`define RFSDC_CFG_RST     24'h000080
`define RFSDC_CLK_RST     24'h000000
`define RFSDC_TRIM_RST    24'h008000
`define RFSDC_CFG0_MASK   24'h3fffed
`define RFSDC_CFG1_MASK   24'h3ffffe
`define RFSDC_CLK_MASK    24'h3fdf7f
`define RFSDC_TRIM_MASK   24'h07f000
`define RFSDC_ATT_FULL    2'h2
`endif

// ---- rfsdc_pkg.sv ----
// types shared by the synthesizer divider and keying block
// assumes no map header values; field widths are set here, and the enum sets the amplifier state codes
package rfsdc_pkg;
    typedef enum logic [1:0] {PA_FULL, PA_ATT10, PA_ATT20, PA_OFF} rfsdc_pa_e;
    typedef struct packed {
        logic [23:0] cfg0;
        logic [23:0] cfg1;
        logic [23:0] clkdiv;
        logic [23:0] trim;
        logic        ack;
        logic [31:0] rdata;
        logic [2:0]  s1;
        logic [2:0]  s2;
        logic [2:0]  s3;
        logic [2:0]  filt;
        logic [5:0]  pre_cnt;
        logic [4:0]  sw_cnt;
        logic [8:0]  prog_cnt;
        logic        fdiv;
        logic [7:0]  ref_cnt;
        logic        fref;
        logic        up;
        logic        dn;
        logic [6:0]  l_cnt;
        logic        dcdc_clk;
        rfsdc_pa_e   pa;
        logic        pa_on;
        logic        pull;
        logic        vco_en;
        logic [2:0]  cp_sel;
        logic [2:0]  xtrim;
    } rfsdc_state_s;
endpackage : rfsdc_pkg

// ---- rfsdc_host.sv ----
// host pin model: keying data and mode select, plus a slow oscillator
// assumes the bench raises its requests just after CLK_SYS rises
`timescale 1ns/1ns
// a far receiver with its oscillator above the carrier inverts the data;
// LO_ABOVE makes the host pre-invert so the far end reads true levels
module rfsdc_host #(
    parameter bit LO_ABOVE = 1'b0
) (
    input  wire logic CLK_SYS,
    input  wire logic key_req,
    input  wire logic rx_req,
    input  wire logic mode_req,
    input  wire logic vco_req,
    output logic      TX_DATA,
    output logic      MODE,
    output logic      VCO_IN
);
    logic [1:0] ph_reg;
    //=======================================================================
    // pins start low so the block never sees an unknown level
    initial begin
        TX_DATA = 1'b0;
        MODE    = 1'b0;
        VCO_IN  = 1'b0;
        ph_reg  = 2'h0;
    end
    //=======================================================================
    // key forced low in receive, else the local oscillator is pulled off
    always @(posedge CLK_SYS) begin
        TX_DATA <= (key_req ^ LO_ABOVE) & ~rx_req;
        MODE    <= mode_req;
        ph_reg  <= ph_reg + 2'h1;
        // oscillator stand-in: 8 cycle period, slow enough for the syncs
        if (vco_req && ph_reg == 2'h3) begin
            VCO_IN <= ~VCO_IN;
        end
    end
endmodule : rfsdc_host

// ---- rfsdc_tb.sv ----
// self-checking bench for the synthesizer divider and keying block
// assumes rfsdc_top, rfsdc_host and the map header; prescaler shortened
`timescale 1ns/1ns
`include "rfsdc_map.svh"
module tb;
    import rfsdc_pkg::*;
    localparam int P = 4;
    logic        clk_sys, rst_b, rd, wr, key, rx, mode_s, vco_on;
    logic [4:0]  adr;
    logic [31:0] wd, rdata, rdat;
    logic [3:0]  be;
    logic        wreq, tx_data, mode, vco_in, fdiv, fref, up, dn;
    logic        pa_on, pull, vco_en, dcdc;
    logic [2:0]  cp_sel, xtrim;
    logic [1:0]  pa_state;
    int          n_fail, samples_checked, cyc;
    rfsdc_host i_rfsdc_host (.CLK_SYS(clk_sys), .key_req(key), .rx_req(rx),
        .mode_req(mode_s), .vco_req(vco_on), .TX_DATA(tx_data),
        .MODE(mode), .VCO_IN(vco_in));
    rfsdc_top #(.PRESC_LO(P)) i_rfsdc_top (.CLK_SYS(clk_sys), .RST_B(rst_b),
        .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wreq), .VCO_IN(vco_in), .TX_DATA(tx_data),
        .MODE(mode), .FDIV_OUT(fdiv), .FREF_OUT(fref), .PUMP_UP(up),
        .PUMP_DN(dn), .CP_SEL(cp_sel), .PA_STATE(pa_state), .PA_ON(pa_on),
        .XTAL_PULL(pull), .XTAL_TRIM(xtrim), .VCO_EN(vco_en),
        .DCDC_CLK(dcdc));
    //=======================================================================
    // shared tasks
    task automatic conclude;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // request held until waitrequest is sampled low, then released
    task automatic bus(input logic w, input logic [2:0] i,
                       input logic [31:0] d);
        @(posedge clk_sys);
        rd  <= ~w;
        wr  <= w;
        adr <= {i, 2'h0};
        wd  <= d;
        do @(posedge clk_sys); while (wreq !== 1'b0);
        rdat = rdata;
        rd  <= 1'b0;
        wr  <= 1'b0;
    endtask : bus
    task automatic wreg(input logic [2:0] i, input logic [31:0] d);
        bus(1'b1, i, d);
        repeat (3) @(posedge clk_sys);
    endtask : wreg
    task automatic rchk(input logic [2:0] i, input logic [31:0] e);
        bus(1'b0, i, 32'h0);
        chk(rdat, e);
    endtask : rchk
    // pins pass a 3-flop sync, so allow a settled margin
    task automatic pin(input logic k, input logic m);
        @(posedge clk_sys);
        key    <= k;
        mode_s <= m;
        repeat (8) @(posedge clk_sys);
    endtask : pin
    // cycles between the second and third rise of fref, fdiv or dcdc
    task automatic gap(input int s, output int n);
        logic p, v;
        int   k;
        p = 1'b1;
        n = 0;
        k = 0;
        repeat (4000) begin
            @(posedge clk_sys);
            v = (s == 0) ? fref : (s == 1) ? fdiv : dcdc;
            if (k == 2) n++;
            if (v === 1'b1 && p === 1'b0) k++;
            p = v;
            if (k == 3) break;
        end
    endtask : gap
    //=======================================================================
    // scenarios
    task automatic t_reset;
        rchk(`RFSDC_OFS_CFG0, 32'h80);
        rchk(`RFSDC_OFS_CFG1, 32'h80);
        rchk(`RFSDC_OFS_CLKDIV, 32'h0);
        rchk(`RFSDC_OFS_TRIM, 32'h8000);
        wreg(3'h5, 32'hffffff);
        rchk(3'h5, 32'h0);
        chk(pa_state, 32'h3);
        chk(vco_en, 32'h1);
        chk(cp_sel, 32'h2);
        chk(up | dn, 32'h0);
        $display("done: reset");
    endtask : t_reset
    task automatic t_amp;
        logic [1:0] st [4];
        st = '{2'h1, 2'h2, 2'h0, 2'h2};
        for (int c = 0; c < 4; c++) begin
            wreg(`RFSDC_OFS_CFG0, (c << 6) | 32'h20);
            chk(pa_state, st[c]);
        end
        pin(1'b1, 1'b0);
        chk(pa_on, 32'h1);
        pin(1'b0, 1'b0);
        chk(pa_on, 32'h0);
        wreg(`RFSDC_OFS_CFG0, 32'h80);
        rx <= 1'b1;
        pin(1'b1, 1'b0);
        chk({pa_state, pa_on, vco_en}, 32'hd);
        rx <= 1'b0;
        $display("done: amplifier");
    endtask : t_amp
    task automatic t_pump;
        logic [2:0] hot [4];
        hot = '{3'h2, 3'h4, 3'h1, 3'h0};
        for (int c = 0; c < 4; c++) begin
            wreg(`RFSDC_OFS_CFG0, c << 2);
            chk(cp_sel, hot[c]);
        end
        $display("done: pump");
    endtask : t_pump
    task automatic t_mode;
        wreg(`RFSDC_OFS_CFG0, 32'h20);
        wreg(`RFSDC_OFS_CFG1, 32'h64);
        pin(1'b0, 1'b1);
        chk({pa_state, cp_sel}, 32'h14);
        pin(1'b0, 1'b0);
        chk({pa_state, cp_sel}, 32'ha);
        $display("done: mode");
    endtask : t_mode
    task automatic t_fsk;
        wreg(`RFSDC_OFS_CFG1, 32'hb0);
        pin(1'b1, 1'b1);
        chk(pull, 32'h1);
        pin(1'b0, 1'b1);
        chk(pull, 32'h0);
        wreg(`RFSDC_OFS_CFG1, 32'ha0);
        pin(1'b1, 1'b1);
        chk({pull, pa_on}, 32'h1);
        pin(1'b0, 1'b0);
        $display("done: keying");
    endtask : t_fsk
    task automatic t_trim;
        wreg(`RFSDC_OFS_TRIM, 32'h058000);
        chk(xtrim, 32'h5);
        rchk(`RFSDC_OFS_TRIM, 32'h058000);
        $display("done: trim");
    endtask : t_trim
    task automatic t_dcdc;
        int n;
        wreg(`RFSDC_OFS_CFG0, 32'h1);
        chk(vco_en, 32'h0);
        wreg(`RFSDC_OFS_CLKDIV, 32'h8);
        chk(vco_en, 32'h1);
        gap(2, n);
        chk(n, 32'd16);
        wreg(`RFSDC_OFS_CLKDIV, 32'h1);
        gap(2, n);
        chk(n, 32'd2);
        wreg(`RFSDC_OFS_CLKDIV, 32'h7f);
        gap(2, n);
        chk(n, 32'd254);
        $display("done: converter");
    endtask : t_dcdc
    task automatic t_ref;
        int n;
        wreg(`RFSDC_OFS_CLKDIV, 32'h0);
        gap(0, n);
        chk(n, 32'd256);
        wreg(`RFSDC_OFS_CLKDIV, 32'h10000);
        gap(0, n);
        chk(n, 32'd4);
        $display("done: reference");
    endtask : t_ref
    task automatic t_div;
        int n;
        vco_on <= 1'b1;
        wreg(`RFSDC_OFS_CFG0, 32'h040300);
        gap(1, n);
        chk(n, (2 + P * 3) * 8);
        wreg(`RFSDC_OFS_CFG0, 32'h3e1f00);
        gap(1, n);
        chk(n, (31 + P * 31) * 8);
        vco_on <= 1'b0;
        $display("done: main divider");
    endtask : t_div
    task automatic t_pfd;
        wreg(`RFSDC_OFS_TRIM, 32'h8000);
        repeat (20) @(posedge clk_sys);
        chk({up, dn}, 32'h0);
        wreg(`RFSDC_OFS_TRIM, 32'h0);
        repeat (20) @(posedge clk_sys);
        chk({up, dn}, 32'h2);
        bus(1'b0, `RFSDC_OFS_STATUS, 32'h0);
        chk(rdat & 32'hfffffffe, 32'h22c);
        $display("done: phase detector");
    endtask : t_pfd
    //=======================================================================
    // clock, hang guard and main sequence
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        {rd, wr, key, rx, mode_s, vco_on, rst_b} = 7'h0;
        n_fail          = 0;
        samples_checked = 0;
        cyc             = 0;
        adr = 5'h0;
        wd  = 32'h0;
        be  = 4'hf;
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset();
        t_amp();
        t_pump();
        t_mode();
        t_fsk();
        t_trim();
        t_dcdc();
        t_ref();
        t_div();
        t_pfd();
        conclude();
    end
endmodule : tb
